// [core/ep0_pkg.sv]
package ep0_pkg;
    localparam int PKT_MAX          = 64;
    localparam int SETUP_BYTES      = 8;
    localparam logic [2:0] LEN_LOW_IDX  = 3'h6;
    localparam logic [2:0] LEN_HIGH_IDX = 3'h7;
    localparam logic [15:0] PTR_RESET   = 16'h0000;
    localparam logic [6:0] PKT_MAX_CNT  = 7'h40;
    localparam int RAM_LATENCY      = 1;
endpackage

// [core/ep0_setup_if.sv]
`timescale 1ns/1ps
interface ep0_setup_if;
    logic       wr;
    logic [2:0] idx;
    logic [7:0] data;
    logic [15:0] req_len;
    logic       done;
    modport store (input wr, input idx, input data, output req_len,
                   output done);
    modport user  (output wr, output idx, output data, input req_len,
                   input done);
endinterface

// [core/ep0_setup_store.sv]
`timescale 1ns/1ps
module ep0_setup_store (
    input  wire logic    ref_clk,
    input  wire logic    rst,
    input  wire logic    clk_en,
    ep0_setup_if.store   sif
);
    // setup_packet_ram: the eight setup bytes
    logic [7:0] setup_q [ep0_pkg::SETUP_BYTES];
    logic       done_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < ep0_pkg::SETUP_BYTES; i++) begin
                setup_q[i] <= 8'h00;
            end
            done_q <= 1'b0;
        end else if (clk_en) begin
            done_q <= sif.wr && (sif.idx == 3'h7);
            if (sif.wr) begin
                setup_q[sif.idx] <= sif.data;
            end
        end
    end

    // length bytes at positions 6 and 7
    assign sif.req_len = {setup_q[ep0_pkg::LEN_HIGH_IDX],
                          setup_q[ep0_pkg::LEN_LOW_IDX]};
    assign sif.done    = done_q;
endmodule

// [core/ep0_autoxfer.sv]
`timescale 1ns/1ps
module ep0_autoxfer (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        setup_wr,
    input  wire logic [2:0]  setup_idx,
    input  wire logic [7:0]  setup_byte,
    output logic             setup_available_irq,
    input  wire logic        ptr_high_wr,
    input  wire logic        ptr_low_wr,
    input  wire logic [7:0]  fw_wdata,
    input  wire logic        handshake_nak_bit_clear_wr,
    output logic             handshake_nak_bit,
    output logic [15:0]      setup_data_pointer,
    output logic [15:0]      ram_addr,
    output logic             ram_rd,
    input  wire logic [7:0]  ram_rdata,
    output logic             in_wr,
    output logic [5:0]       in_idx,
    output logic [7:0]       in_data,
    output logic             in_arm,
    output logic [6:0]       ep_zero_in_byte_count,
    input  wire logic        in_ack,
    input  wire logic        in_fail,
    input  wire logic        out_pkt,
    input  wire logic [6:0]  out_cnt,
    input  wire logic        out_bc_wr,
    output logic             out_armed,
    input  wire logic        status_token,
    output logic             status_ack,
    output logic             status_nak,
    output logic             busy
);
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_LEN  = 6'b000010,
        S_FILL = 6'b000100,
        S_SEND = 6'b001000,
        S_WAIT = 6'b010000,
        S_STAT = 6'b100000
    } state_t;

    state_t      st_q, st_d;
    logic [7:0]  setup_pointer_high, setup_pointer_low;
    logic        handshake_nak_bit_q;
    logic [15:0] remain_q, base_q, rx_cnt_q;
    logic [6:0]  fill_q, pkt_len_q;
    logic        zlp_q, rd_q, irq_q, armed_q, wr_q;
    logic [15:0] ptr_w, min_w;
    logic [6:0]  chunk_w;
    logic        last_w, fill_done_w, out_done_w;

    ep0_setup_if sif ();
    assign sif.wr   = setup_wr;
    assign sif.idx  = setup_idx;
    assign sif.data = setup_byte;
    ep0_setup_store u_store (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .sif     (sif)
    );

    function automatic logic [15:0] min16(input logic [15:0] a,
                                          input logic [15:0] b);
        return (a < b) ? a : b;
    endfunction

    function automatic logic [6:0] chunk_of(input logic [15:0] left);
        return (left > 16'(ep0_pkg::PKT_MAX_CNT))
               ? ep0_pkg::PKT_MAX_CNT : left[6:0];
    endfunction

    assign ptr_w       = {setup_pointer_high, setup_pointer_low};
    assign min_w       = min16(sif.req_len, {8'h00, ram_rdata});
    assign chunk_w     = chunk_of(remain_q);
    assign fill_done_w = (fill_q == pkt_len_q);
    assign last_w      = (remain_q == 16'h0000) && !zlp_q;
    assign out_done_w  = (rx_cnt_q >= sif.req_len);

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            S_IDLE: if (ptr_low_wr) st_d = S_LEN;
            S_LEN:  if (!rd_q) st_d = S_FILL;
            S_FILL: if (fill_done_w && !rd_q) st_d = S_SEND;
            S_SEND: st_d = S_WAIT;
            S_WAIT: begin
                if (in_fail) st_d = S_SEND;
                else if (in_ack) st_d = last_w ? S_STAT : S_FILL;
            end
            S_STAT: if (status_token && !handshake_nak_bit_q) st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= S_IDLE;
            setup_pointer_high <= ep0_pkg::PTR_RESET[15:8];
            setup_pointer_low  <= ep0_pkg::PTR_RESET[7:0];
            handshake_nak_bit_q   <= 1'b0;
            remain_q  <= 16'h0000;
            base_q    <= 16'h0000;
            fill_q    <= 7'h00;
            pkt_len_q <= 7'h00;
            zlp_q     <= 1'b0;
            rd_q      <= 1'b0;
            irq_q     <= 1'b0;
            rx_cnt_q  <= 16'h0000;
            armed_q   <= 1'b0;
            wr_q      <= 1'b0;
        end else if (clk_en) begin
            st_q  <= st_d;
            irq_q <= sif.done;
            if (ptr_high_wr) setup_pointer_high <= fw_wdata;
            if (ptr_low_wr)  setup_pointer_low  <= fw_wdata;
            // set wins over firmware clear: a new setup re-naks
            if (sif.done) handshake_nak_bit_q <= 1'b1;
            else if (handshake_nak_bit_clear_wr) handshake_nak_bit_q <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            if (st_q == S_IDLE && ptr_low_wr) begin
                base_q <= {setup_pointer_high, fw_wdata};
                rd_q   <= 1'b1;
            end
            // length byte stands one cycle after the read strobe
            if (st_q == S_LEN && !rd_q) begin
                remain_q  <= min_w;
                // descriptor shorter than asked and packet-aligned
                zlp_q <= (min_w < sif.req_len)
                         && (min_w[5:0] == 6'h00);
                fill_q    <= 7'h00;
                pkt_len_q <= chunk_of(min_w);
            end
            if (st_q == S_WAIT && in_ack) begin
                if (remain_q == 16'h0000) zlp_q <= 1'b0;
                fill_q    <= 7'h00;
                pkt_len_q <= chunk_w;
            end
            if (st_q == S_FILL && !fill_done_w && !rd_q) begin
                rd_q <= 1'b1;
            end
            if (st_q == S_FILL && rd_q) begin
                wr_q     <= 1'b1;
                fill_q   <= fill_q + 7'h01;
                base_q   <= base_q + 16'h0001;
            end
            if (st_q == S_SEND && fill_q == pkt_len_q) begin
                remain_q <= remain_q - 16'(pkt_len_q);
            end
            // keep remaining count stable across resends
            if (st_q == S_WAIT && in_fail) begin
                remain_q <= remain_q + 16'(pkt_len_q);
            end
            if (sif.done) rx_cnt_q <= 16'h0000;
            else if (out_pkt) rx_cnt_q <= rx_cnt_q + 16'(out_cnt);
            if (out_pkt) armed_q <= 1'b0;
            else if (out_bc_wr || sif.done) armed_q <= 1'b1;
        end
    end

    // first packet length is set when the length read completes
    assign setup_data_pointer    = ptr_w;
    assign handshake_nak_bit     = handshake_nak_bit_q;
    assign setup_available_irq   = irq_q;
    assign ram_addr              = base_q;
    assign ram_rd                = rd_q;
    assign in_wr                 = wr_q;
    assign in_idx                = fill_q[5:0] - 6'h01;
    assign in_data               = ram_rdata;
    assign in_arm                = (st_q == S_SEND);
    assign ep_zero_in_byte_count = pkt_len_q;
    assign out_armed             = armed_q;
    assign busy                  = (st_q != S_IDLE);
    // status answered by hardware once nak released and data done
    assign status_ack = status_token && !handshake_nak_bit_q
                        && ((st_q == S_STAT)
                            || (st_q == S_IDLE && out_done_w));
    assign status_nak = status_token && !status_ack;

    AST_NAK_HOLDS: assert property (
        @(posedge ref_clk) disable iff (rst)
        handshake_nak_bit_q |-> !status_ack)
        else $error("status acked while nak bit set");
    AST_IRQ_AFTER_SETUP: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && sif.done |=> irq_q)
        else $error("setup interrupt missing");
    AST_START: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && st_q == S_IDLE && ptr_low_wr |=> st_q == S_LEN)
        else $error("low pointer write did not start transfer");
    AST_PKT_MAX: assert property (
        @(posedge ref_clk) disable iff (rst)
        pkt_len_q <= ep0_pkg::PKT_MAX_CNT)
        else $error("packet longer than 64");
    AST_RETRY: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && st_q == S_WAIT && in_fail |=> st_q == S_SEND)
        else $error("failed packet not resent");
    AST_PTR_HIGH: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && ptr_high_wr |=> setup_pointer_high == $past(fw_wdata))
        else $error("pointer high not written");
    AST_REARM: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && out_bc_wr && !out_pkt |=> armed_q)
        else $error("out endpoint not re-armed");
    AST_STATUS_END: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && st_q == S_STAT && status_ack |=> st_q == S_IDLE)
        else $error("status stage did not close");
endmodule

// [tb/usb_host_model.sv]
`timescale 1ns/1ps
module usb_host_model (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       in_arm,
    input  wire logic [6:0] byte_count,
    input  wire logic       fail_req,
    input  wire logic       slow,
    output logic            in_ack,
    output logic            in_fail,
    output int              pkts,
    output int              bytes
);
    int   wait_q;
    logic pend_q;
    logic failed_q;
    // one failed delivery per request, so retries stay bounded
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            in_ack   <= 1'b0;
            in_fail  <= 1'b0;
            pend_q   <= 1'b0;
            failed_q <= 1'b0;
            wait_q   <= 0;
            pkts     <= 0;
            bytes    <= 0;
        end else begin
            in_ack  <= 1'b0;
            in_fail <= 1'b0;
            if (!fail_req) failed_q <= 1'b0;
            if (in_arm) begin
                pend_q <= 1'b1;
                wait_q <= slow ? 6 : 1;
            end else if (pend_q && wait_q > 0) begin
                wait_q <= wait_q - 1;
            end else if (pend_q) begin
                pend_q <= 1'b0;
                if (fail_req && !failed_q) begin
                    in_fail  <= 1'b1;
                    failed_q <= 1'b1;
                end else begin
                    in_ack <= 1'b1;
                    pkts   <= pkts + 1;
                    bytes  <= bytes + int'(byte_count);
                end
            end
        end
    end
endmodule

// [tb/test_ep0_autoxfer.sv]
`timescale 1ns/1ps
module test_ep0_autoxfer;
    logic        ref_clk = 1'b0, rst = 1'b1, setup_wr = 1'b0;
    logic        ptr_high_wr = 1'b0, ptr_low_wr = 1'b0, handshake_nak_bit_clear_wr = 1'b0;
    logic        out_pkt = 1'b0, out_bc_wr = 1'b0, status_token = 1'b0;
    logic        fail_req = 1'b0, slow = 1'b0, clk_en = 1'b1;
    logic [9:0]  exp_idx;
    localparam int P_NAK = 0;
    localparam int P_OUT = 1;
    localparam int P_BC  = 2;
    logic [2:0]  setup_idx = 3'h0;
    logic [7:0]  setup_byte = 8'h00, fw_wdata = 8'h00, ram_rdata = 8'h00;
    logic [6:0]  out_cnt = 7'h00;
    logic [7:0]  mem [1024];
    logic        setup_available_irq, handshake_nak_bit, ram_rd, in_wr;
    logic        in_arm, in_ack, in_fail, out_armed, status_ack, status_nak;
    logic        busy;
    logic [15:0] setup_data_pointer, ram_addr, cur_ptr = 16'h0000;
    logic [5:0]  in_idx;
    logic [7:0]  in_data;
    logic [6:0]  ep_zero_in_byte_count;
    int          pkts, bytes, base = 0, num_errors = 0, total_checks = 0;

    ep0_autoxfer i_ep0_autoxfer (.ref_clk, .rst, .clk_en, .setup_wr,
        .setup_idx, .setup_byte, .setup_available_irq, .ptr_high_wr,
        .ptr_low_wr, .fw_wdata, .handshake_nak_bit_clear_wr, .handshake_nak_bit,
        .setup_data_pointer, .ram_addr, .ram_rd, .ram_rdata, .in_wr, .in_idx,
        .in_data, .in_arm, .ep_zero_in_byte_count, .in_ack, .in_fail,
        .out_pkt, .out_cnt, .out_bc_wr, .out_armed, .status_token,
        .status_ack, .status_nak, .busy);
    usb_host_model i_usb_host_model (.ref_clk, .rst, .in_arm,
        .byte_count(ep_zero_in_byte_count), .fail_req, .slow, .in_ack,
        .in_fail, .pkts, .bytes);

    initial forever #2.5 ref_clk = ~ref_clk;
    // idle read port drifts so stale data cannot pass
    always @(posedge ref_clk) begin
        ram_rdata <= ram_rd ? mem[ram_addr[9:0]] : ~ram_rdata;
    end
    assign exp_idx = 10'(int'(cur_ptr) + bytes - base + int'(in_idx));
    always @(posedge ref_clk) begin
        if (in_wr) check(in_data === mem[exp_idx], "in data");
        if (in_arm) check(ep_zero_in_byte_count <= 7'h40, "size");
    end

    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic pulse(input int sel);
        @(posedge ref_clk);
        case (sel)
            P_NAK:   handshake_nak_bit_clear_wr <= 1'b1;
            P_OUT:   out_pkt <= 1'b1;
            default: out_bc_wr <= 1'b1;
        endcase
        @(posedge ref_clk);
        handshake_nak_bit_clear_wr <= 1'b0;
        out_pkt <= 1'b0;
        out_bc_wr <= 1'b0;
        #1;
    endtask

    task automatic setup(input logic [7:0] rt, rq, ix, dt,
                         input logic [15:0] len);
        logic [7:0] b [8];
        int got;
        b = '{rt, rq, ix, dt, 8'h00, 8'h00, len[7:0], len[15:8]};
        got = 0;
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            setup_wr <= 1'b1;
            setup_idx <= 3'(i);
            setup_byte <= b[i];
        end
        @(posedge ref_clk);
        setup_wr <= 1'b0;
        repeat (4) begin
            #1 if (setup_available_irq === 1'b1) got++;
            @(posedge ref_clk);
        end
        check(got == 1, "irq pulse");
        check(handshake_nak_bit === 1'b1, "nak set");
    endtask

    task automatic status(input logic exp);
        @(posedge ref_clk);
        status_token <= 1'b1;
        #1 check(status_ack === exp, "status ack");
        check(status_nak === !exp, "status nak");
        @(posedge ref_clk);
        status_token <= 1'b0;
    endtask

    // req is type:code, val is descriptor type:index
    task automatic get_desc(input logic [15:0] req, val, p, len);
        int ex;
        int np;
        ex = (len < 16'(mem[p[9:0]])) ? int'(len) : int'(mem[p[9:0]]);
        np = (ex + 63) / 64 + ((ex % 64 == 0 && ex < len) ? 1 : 0);
        setup(req[15:8], req[7:0], val[7:0], val[15:8], len);
        base = bytes;
        np = np + pkts;
        cur_ptr = p;
        @(posedge ref_clk);
        ptr_high_wr <= 1'b1;
        fw_wdata <= p[15:8];
        @(posedge ref_clk);
        ptr_high_wr <= 1'b0;
        ptr_low_wr <= 1'b1;
        fw_wdata <= p[7:0];
        @(posedge ref_clk);
        ptr_low_wr <= 1'b0;
        #1 check(setup_data_pointer === p, "pointer");
        check(busy === 1'b1, "started");
        for (int i = 0; i < 3000 && pkts < np; i++) @(posedge ref_clk);
        check(pkts == np, "packets");
        check(bytes - base == ex, "bytes");
        status(1'b0);
        pulse(P_NAK);
        status(1'b1);
        #1 check(busy === 1'b0, "closed");
        fail_req <= 1'b0;
    endtask

    task automatic set_desc_test();
        setup(8'h00, 8'h07, 8'h00, 8'h01, 16'h0014);
        pulse(P_NAK);
        out_cnt <= 7'h10;
        pulse(P_OUT);
        check(out_armed === 1'b0, "spent");
        status(1'b0);
        pulse(P_BC);
        check(out_armed === 1'b1, "rearm");
        out_cnt <= 7'h04;
        pulse(P_OUT);
        pulse(P_BC);
        status(1'b1);
    endtask

    // clear while frozen must not land
    task automatic set_config_test();
        setup(8'h00, 8'h09, 8'h05, 8'h00, 16'h0000);
        clk_en <= 1'b0;
        pulse(P_NAK);
        check(handshake_nak_bit === 1'b1, "frozen");
        status(1'b0);
        clk_en <= 1'b1;
        pulse(P_NAK);
        status(1'b1);
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        final_report();
    end

    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = 8'(i * 5 + 1);
        mem[10'h100] = 8'h12;
        mem[10'h200] = 8'h5B;
        mem[10'h300] = 8'h40;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        get_desc(16'h8006, 16'h0100, 16'h0100, 16'h0040);
        slow <= 1'b1;
        fail_req <= 1'b1;
        get_desc(16'h8006, 16'h0200, 16'h0200, 16'h00FF);
        get_desc(16'h8006, 16'h0301, 16'h0200, 16'h000A);
        get_desc(16'h8006, 16'h0100, 16'h0300, 16'h0064);
        get_desc(16'hC042, 16'h0000, 16'h0100, 16'h0005);
        set_desc_test();
        set_config_test();
        final_report();
    end
endmodule
